//--- verilog/vtpc_defs.svh
// vtpc_defs.svh: register indices, field positions, reset values and pattern codes
// assumes: included by the timing and top design files of the test pattern control block
`ifndef VTPC_DEFS_SVH
`define VTPC_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define VTPC_IDX_CTRL     8'h64
`define VTPC_IDX_CFG      8'h65
`define VTPC_IDX_IADDR    8'h66
`define VTPC_IDX_IDATA    8'h67
`define VTPC_IDX_STAT     8'h68
`define VTPC_ADDR_W       10

// control register fields
`define VTPC_CTRL_EN      0
`define VTPC_CTRL_SEL_HI  6
`define VTPC_CTRL_SEL_LO  4

// configuration register fields
`define VTPC_CFG_SCROLL   0
`define VTPC_CFG_INV      1
`define VTPC_CFG_TSEL     2
`define VTPC_CFG_EXTCLK   3
`define VTPC_CFG_RED      4
`define VTPC_CFG_SCALE    6

// reset values
`define VTPC_RST_BYTE     8'h00
`define VTPC_RST_WORD     32'h0000_0000

// indirect register space
`define VTPC_IND_NUM      16
`define VTPC_IND_HTOT_L   0
`define VTPC_IND_HTOT_H   1
`define VTPC_IND_VTOT_L   2
`define VTPC_IND_VTOT_H   3
`define VTPC_IND_HACT_L   4
`define VTPC_IND_HACT_H   5
`define VTPC_IND_VACT_L   6
`define VTPC_IND_VACT_H   7
`define VTPC_IND_HSW      8
`define VTPC_IND_VSW      9
`define VTPC_IND_HBP      10
`define VTPC_IND_VBP      11
`define VTPC_IND_SYNC     12
`define VTPC_IND_FTIME    13
`define VTPC_IND_MASK     14
`define VTPC_IND_DIV      15

// color depth handling: 18-bit mode clears the two low bits of each color
`define VTPC_MASK_18      8'hfc
`define VTPC_MASK_24      8'hff

// pattern codes
`define VTPC_PAT_WHITE    3'h0
`define VTPC_PAT_BLACK    3'h1
`define VTPC_PAT_RED      3'h2
`define VTPC_PAT_GREEN    3'h3
`define VTPC_PAT_BLUE     3'h4
`define VTPC_PAT_HRAMP    3'h5
`define VTPC_PAT_VRAMP    3'h6
`define VTPC_PAT_CHECK    3'h7

`endif

//--- verilog/vtpc_pkg.sv
// vtpc_pkg.sv: types shared by the test pattern control block
// assumes: vtpc_defs.svh supplies the numbers
package vtpc_pkg;

	// one generated pixel with its sync signals
	typedef struct packed {
		logic       de;
		logic       hs;
		logic       vs;
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} vtpc_pixel_t;

	// programmed self-timing values
	typedef struct packed {
		logic [11:0] htotal;
		logic [11:0] vtotal;
		logic [11:0] hact;
		logic [11:0] vact;
		logic [7:0]  hsw;
		logic [7:0]  vsw;
		logic [7:0]  hbp;
		logic [7:0]  vbp;
		logic        hs_pol;
		logic        vs_pol;
	} vtpc_timing_cfg_t;

	// timing state seen by the pattern logic
	typedef struct packed {
		logic        de;
		logic        hs;
		logic        vs;
		logic        frame_start;
		logic [11:0] x;
		logic [11:0] y;
	} vtpc_timing_t;

endpackage

//--- verilog/vtpc_timing.sv
// vtpc_timing.sv: self-generated raster timing for the pattern generator
// assumes: step marks one pixel period, run is a level from the same clock
`timescale 1ns/1ps
`include "vtpc_defs.svh"

module vtpc_timing
	import vtpc_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             run,
	input  wire logic             step,
	input  wire vtpc_timing_cfg_t cfg,
	output vtpc_timing_t          tm_q
);

	logic [11:0]  h_q;
	logic [11:0]  h_d;
	logic [11:0]  v_q;
	logic [11:0]  v_d;
	vtpc_timing_t tm_d;
	logic [11:0]  hstart;
	logic [11:0]  vstart;

	assign hstart = {4'h0, cfg.hsw} + {4'h0, cfg.hbp};
	assign vstart = {4'h0, cfg.vsw} + {4'h0, cfg.vbp};

	////////////////////////////////////////////////////////////////////////
	// raster counters
	always_comb begin
		h_d = h_q;
		v_d = v_q;
		if (!run) begin
			h_d = 12'h000;
			v_d = 12'h000;
		end else if (step) begin
			if (h_q + 12'h001 >= cfg.htotal) begin
				h_d = 12'h000;
				v_d = (v_q + 12'h001 >= cfg.vtotal) ? 12'h000 : v_q + 12'h001;
			end else begin
				h_d = h_q + 12'h001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			h_q <= 12'h000;
			v_q <= 12'h000;
		end else begin
			h_q <= h_d;
			v_q <= v_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decoded sync, enable and pixel position; idle levels while not running
	always_comb begin
		tm_d.hs          = run ? ((h_q < {4'h0, cfg.hsw}) ~^ cfg.hs_pol) : ~cfg.hs_pol;
		tm_d.vs          = run ? ((v_q < {4'h0, cfg.vsw}) ~^ cfg.vs_pol) : ~cfg.vs_pol;
		tm_d.de          = run && (h_q >= hstart) && (h_q < hstart + cfg.hact)
		                       && (v_q >= vstart) && (v_q < vstart + cfg.vact);
		tm_d.frame_start = run && step && (h_q == 12'h000) && (v_q == 12'h000);
		tm_d.x           = h_q - hstart;
		tm_d.y           = v_q - vstart;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tm_q <= '0;
		end else begin
			tm_q <= tm_d;
		end
	end

endmodule

//--- verilog/vtpc_top.sv
// vtpc_top.sv: video test pattern control, APB slave plus pattern engine
// assumes: APB master on pclk, video pins asynchronous to pclk
//
// Functional notes
// - reduced color: 64 steps, six MSBs only
// - self timing: divided clock or external clock
// - external timing ignores clock-source bit
// - timing select clear follows external video timing
// - timing select set uses programmed timing values
// - invert bit inverts output colors
// - scroll clear holds selected pattern
// - indirect address register, 8 bits, reset zero
// - data write stores into addressed indirect register
// - data read returns addressed indirect register
// - enable bit gates all pattern output
`timescale 1ns/1ps
`include "vtpc_defs.svh"

module vtpc_top
	import vtpc_pkg::*;
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`VTPC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    pix_clk_in,
	input  wire logic                    ext_de_in,
	input  wire logic                    ext_hs_in,
	input  wire logic                    ext_vs_in,
	output vtpc_pixel_t                  video_out,
	output logic                         video_valid,
	output logic                         pgen_active
);

	logic [7:0]       ctrl_q;
	logic [7:0]       ctrl_d;
	logic [7:0]       cfg_q;
	logic [7:0]       cfg_d;
	logic [7:0]       indirect_address_reg_q;
	logic [7:0]       indirect_address_reg_d;
	logic [7:0]       ind_q [`VTPC_IND_NUM];
	logic [7:0]       ind_d [`VTPC_IND_NUM];
	logic [31:0]      prdata_q;
	logic [31:0]      prdata_d;
	logic             err_q;
	logic             err_d;
	logic             setup;
	logic             wr_acc;
	logic [7:0]       idx;
	logic             mapped;
	logic [7:0]       indirect_data_reg;
	logic [7:0]       stat;
	logic             gen_en;
	logic             timing_source_select;
	logic             reduced_color_select;
	logic [3:0]       sync1_q;
	logic [3:0]       sync2_q;
	logic [3:0]       sync3_q;
	logic [3:0]       filt_q;
	logic [3:0]       filt_d;
	logic [3:0]       prev_q;
	logic [7:0]       div_q;
	logic [7:0]       div_d;
	logic             int_tick;
	logic             ext_tick;
	logic             step;
	logic             step_q;
	logic [11:0]      ex_q;
	logic [11:0]      ex_d;
	logic [11:0]      ey_q;
	logic [11:0]      ey_d;
	vtpc_timing_cfg_t tcfg;
	vtpc_timing_t     gen_tm;
	vtpc_timing_t     ext_tm;
	vtpc_timing_t     tm;
	logic [2:0]       cur_pat_q;
	logic [2:0]       cur_pat_d;
	logic [7:0]       fcnt_q;
	logic [7:0]       fcnt_d;
	vtpc_pixel_t      pix_q;
	vtpc_pixel_t      pix_d;
	logic             valid_q;
	logic             valid_d;

	// first enabled pattern after the current one, current if none enabled
	function automatic logic [2:0] next_pat(input logic [2:0] cur, input logic [7:0] mask);
		logic [2:0] cand;
		logic       found;
		next_pat = cur;
		found    = 1'b0;
		for (int k = 1; k <= 8; k++) begin
			cand = cur + k[2:0];
			if (!found && mask[cand]) begin
				next_pat = cand;
				found    = 1'b1;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// APB decode: zero wait states, unmapped or unaligned address errors
	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign idx    = paddr[`VTPC_ADDR_W-1:2];
	assign mapped = (paddr[1:0] == 2'b00) && (idx >= `VTPC_IDX_CTRL) && (idx <= `VTPC_IDX_STAT);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && err_q;
	assign prdata  = prdata_q;

	assign gen_en               = ctrl_q[`VTPC_CTRL_EN];
	assign timing_source_select = cfg_q[`VTPC_CFG_TSEL];
	assign reduced_color_select = cfg_q[`VTPC_CFG_RED];
	assign pgen_active          = gen_en;

	assign indirect_data_reg = (indirect_address_reg_q < 8'(`VTPC_IND_NUM))
	                           ? ind_q[indirect_address_reg_q[3:0]] : `VTPC_RST_BYTE;
	assign stat = {4'h0, cur_pat_q, gen_en};

	// read data and error are captured in setup so they stand through access
	always_comb begin
		prdata_d = prdata_q;
		err_d    = err_q;
		if (setup) begin
			err_d    = !mapped;
			prdata_d = `VTPC_RST_WORD;
			if (!pwrite) begin
				case (idx)
					`VTPC_IDX_CTRL:  prdata_d = {24'h000000, ctrl_q};
					`VTPC_IDX_CFG:   prdata_d = {24'h000000, cfg_q};
					`VTPC_IDX_IADDR: prdata_d = {24'h000000, indirect_address_reg_q};
					`VTPC_IDX_IDATA: prdata_d = {24'h000000, indirect_data_reg};
					`VTPC_IDX_STAT:  prdata_d = {24'h000000, stat};
					default:         prdata_d = `VTPC_RST_WORD;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= `VTPC_RST_WORD;
			err_q    <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			err_q    <= err_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// direct registers; the config bit 7 is reserved and reads zero
	always_comb begin
		ctrl_d                 = ctrl_q;
		cfg_d                  = cfg_q;
		indirect_address_reg_d = indirect_address_reg_q;
		if (wr_acc) begin
			case (idx)
				`VTPC_IDX_CTRL:  ctrl_d = pwdata[7:0];
				`VTPC_IDX_CFG:   cfg_d  = {1'b0, pwdata[6:0]};
				`VTPC_IDX_IADDR: indirect_address_reg_d = pwdata[7:0];
				default:         ctrl_d = ctrl_q;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q                 <= `VTPC_RST_BYTE;
			cfg_q                  <= `VTPC_RST_BYTE;
			indirect_address_reg_q <= `VTPC_RST_BYTE;
		end else begin
			ctrl_q                 <= ctrl_d;
			cfg_q                  <= cfg_d;
			indirect_address_reg_q <= indirect_address_reg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// indirect register file, one flop byte per entry
	for (genvar i = 0; i < `VTPC_IND_NUM; i++) begin : g_ind
		always_comb begin
			ind_d[i] = ind_q[i];
			if (wr_acc && idx == `VTPC_IDX_IDATA && indirect_address_reg_q == 8'(i)) begin
				ind_d[i] = pwdata[7:0];
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ind_q[i] <= `VTPC_RST_BYTE;
			end else begin
				ind_q[i] <= ind_d[i];
			end
		end
	end

	// programmed timing gathered from the indirect space
	assign tcfg.htotal = {ind_q[`VTPC_IND_HTOT_H][3:0], ind_q[`VTPC_IND_HTOT_L]};
	assign tcfg.vtotal = {ind_q[`VTPC_IND_VTOT_H][3:0], ind_q[`VTPC_IND_VTOT_L]};
	assign tcfg.hact   = {ind_q[`VTPC_IND_HACT_H][3:0], ind_q[`VTPC_IND_HACT_L]};
	assign tcfg.vact   = {ind_q[`VTPC_IND_VACT_H][3:0], ind_q[`VTPC_IND_VACT_L]};
	assign tcfg.hsw    = ind_q[`VTPC_IND_HSW];
	assign tcfg.vsw    = ind_q[`VTPC_IND_VSW];
	assign tcfg.hbp    = ind_q[`VTPC_IND_HBP];
	assign tcfg.vbp    = ind_q[`VTPC_IND_VBP];
	assign tcfg.hs_pol = ind_q[`VTPC_IND_SYNC][0];
	assign tcfg.vs_pol = ind_q[`VTPC_IND_SYNC][1];

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: {vs, hs, de, clk}; a change counts once stages 2 and 3 agree
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			filt_d[b] = (sync2_q[b] == sync3_q[b]) ? sync3_q[b] : filt_q[b];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
			sync3_q <= 4'h0;
			filt_q  <= 4'h0;
			prev_q  <= 4'h0;
		end else begin
			sync1_q <= {ext_vs_in, ext_hs_in, ext_de_in, pix_clk_in};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q  <= filt_d;
			prev_q  <= filt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pixel step: divided internal tick or sampled external clock edge
	assign int_tick = (div_q >= ind_q[`VTPC_IND_DIV]);
	assign ext_tick = filt_q[0] && !prev_q[0];
	// clock source only in self timing
	assign step = (timing_source_select && !cfg_q[`VTPC_CFG_EXTCLK]) ? int_tick : ext_tick;

	always_comb begin
		div_d = int_tick ? 8'h00 : div_q + 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q  <= 8'h00;
			step_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			step_q <= step;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// external timing: position counted from the sampled enable and sync
	always_comb begin
		ex_d = ex_q;
		ey_d = ey_q;
		if (filt_q[3] && !prev_q[3]) begin
			ey_d = 12'h000;
		end else if (!filt_q[1] && prev_q[1]) begin
			ex_d = 12'h000;
			ey_d = ey_q + 12'h001;
		end else if (ext_tick && filt_q[1]) begin
			ex_d = ex_q + 12'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ex_q <= 12'h000;
			ey_q <= 12'h000;
		end else begin
			ex_q <= ex_d;
			ey_q <= ey_d;
		end
	end

	assign ext_tm.de          = filt_q[1];
	assign ext_tm.hs          = filt_q[2];
	assign ext_tm.vs          = filt_q[3];
	assign ext_tm.frame_start = filt_q[3] && !prev_q[3];
	assign ext_tm.x           = ex_q;
	assign ext_tm.y           = ey_q;

	// self timing runs only when enabled
	vtpc_timing u_timing (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (gen_en && timing_source_select),
		.step    (step),
		.cfg     (tcfg),
		.tm_q    (gen_tm)
	);

	assign tm = timing_source_select ? gen_tm : ext_tm;

	////////////////////////////////////////////////////////////////////////
	// pattern selection and auto scroll
	always_comb begin
		cur_pat_d = cur_pat_q;
		fcnt_d    = fcnt_q;
		if (!cfg_q[`VTPC_CFG_SCROLL]) begin
			cur_pat_d = ctrl_q[`VTPC_CTRL_SEL_HI:`VTPC_CTRL_SEL_LO];
			fcnt_d    = 8'h00;
		end else if (gen_en && tm.frame_start) begin
			if (fcnt_q + 8'h01 >= ind_q[`VTPC_IND_FTIME]) begin
				fcnt_d    = 8'h00;
				cur_pat_d = next_pat(cur_pat_q, ind_q[`VTPC_IND_MASK]);
			end else begin
				fcnt_d = fcnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_pat_q <= `VTPC_PAT_WHITE;
			fcnt_q    <= 8'h00;
		end else begin
			cur_pat_q <= cur_pat_d;
			fcnt_q    <= fcnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pixel colors; 18-bit depth masks after inversion so ramps keep 64 steps
	always_comb begin
		logic [7:0] lvl;
		logic [7:0] cmask;
		logic       chk;
		lvl   = 8'h00;
		cmask = reduced_color_select ? `VTPC_MASK_18 : `VTPC_MASK_24;
		chk   = cfg_q[`VTPC_CFG_SCALE] ? (tm.x[3] ^ tm.y[3]) : (tm.x[0] ^ tm.y[0]);
		pix_d = '0;
		case (cur_pat_q)
			`VTPC_PAT_WHITE: {pix_d.r, pix_d.g, pix_d.b} = {3{8'hff}};
			`VTPC_PAT_BLACK: {pix_d.r, pix_d.g, pix_d.b} = {3{8'h00}};
			`VTPC_PAT_RED:   pix_d.r = 8'hff;
			`VTPC_PAT_GREEN: pix_d.g = 8'hff;
			`VTPC_PAT_BLUE:  pix_d.b = 8'hff;
			`VTPC_PAT_HRAMP: lvl = tm.x[7:0];
			`VTPC_PAT_VRAMP: lvl = tm.y[7:0];
			`VTPC_PAT_CHECK: lvl = chk ? 8'hff : 8'h00;
			default:         lvl = 8'h00;
		endcase
		if (cur_pat_q >= `VTPC_PAT_HRAMP) begin
			lvl = reduced_color_select ? {tm.x[5:0] & {6{cur_pat_q == `VTPC_PAT_HRAMP}} |
			      tm.y[5:0] & {6{cur_pat_q == `VTPC_PAT_VRAMP}} |
			      {6{chk && cur_pat_q == `VTPC_PAT_CHECK}}, 2'b00} : lvl;
			{pix_d.r, pix_d.g, pix_d.b} = {3{lvl}};
		end
		if (cfg_q[`VTPC_CFG_INV]) begin
			{pix_d.r, pix_d.g, pix_d.b} = ~{pix_d.r, pix_d.g, pix_d.b};
		end
		pix_d.r = pix_d.r & cmask;
		pix_d.g = pix_d.g & cmask;
		pix_d.b = pix_d.b & cmask;
		if (!(gen_en && tm.de)) begin
			{pix_d.r, pix_d.g, pix_d.b} = 24'h000000;
		end
		pix_d.de = gen_en && tm.de;
		pix_d.hs = gen_en && tm.hs;
		pix_d.vs = gen_en && tm.vs;
		valid_d  = gen_en && step_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_q   <= '0;
			valid_q <= 1'b0;
		end else begin
			pix_q   <= pix_d;
			valid_q <= valid_d;
		end
	end

	assign video_out   = pix_q;
	assign video_valid = valid_q;

endmodule

//--- sim/vtpc_assertions.sv
// vtpc_assertions.sv: port checks for the test pattern control block
// assumes: bound to vtpc_top, one pclk domain, presetn async low
`timescale 1ns/1ps
`include "vtpc_defs.svh"
module vtpc_assertions
	import vtpc_pkg::*;
(
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [`VTPC_ADDR_W-1:0] paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic                    pix_clk_in,
	input wire logic                    ext_de_in,
	input wire logic                    ext_hs_in,
	input wire logic                    ext_vs_in,
	input wire vtpc_pixel_t             video_out,
	input wire logic                    video_valid,
	input wire logic                    pgen_active
);
	localparam logic [9:0] ACTRL = {`VTPC_IDX_CTRL, 2'b00};
	localparam logic [9:0] ACFG  = {`VTPC_IDX_CFG, 2'b00};
	logic red_q;
	logic red_d;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// shadow of the reduced color bit; only bus writes can move it
	always_comb begin
		red_d = red_q;
		if (psel && penable && pwrite && paddr == ACFG)
			red_d = pwdata[`VTPC_CFG_RED];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			red_q <= 1'b0;
		else
			red_q <= red_d;
	end
	////////////////////////////////////////////////////////////////
	sequence wr_ctrl_s;
		psel && penable && pwrite && paddr == ACTRL;
	endsequence
	sequence off_s;
		!pgen_active [*4];
	endsequence
	ready_always_a: assert property (psel |-> pready)
		else $error("pready low in transfer");
	err_unmapped_a: assert property (psel && penable && (paddr[9:2] < 8'h64
		|| paddr[9:2] > 8'h68) |-> pslverr) else $error("no error on unmapped");
	err_idle_a: assert property (!(psel && penable) |-> !pslverr)
		else $error("pslverr outside access");
	rd_upper_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	en_follow_a: assert property (wr_ctrl_s |=> pgen_active == $past(pwdata[0]))
		else $error("enable not taken");
	off_quiet_a: assert property (off_s |-> video_out == '0 && !video_valid)
		else $error("output while disabled");
	valid_src_a: assert property (video_valid |-> $past(pgen_active) || $past(pgen_active, 2))
		else $error("valid without enable");
	// six msbs only; output lags the config bit by one cycle
	red_mask_a: assert property (red_q && $past(red_q) |-> video_out.r[1:0] == 2'b00
		&& video_out.g[1:0] == 2'b00 && video_out.b[1:0] == 2'b00) else $error("low bits set");
endmodule
bind vtpc_top vtpc_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pix_clk_in(pix_clk_in), .ext_de_in(ext_de_in),
	.ext_hs_in(ext_hs_in), .ext_vs_in(ext_vs_in), .video_out(video_out),
	.video_valid(video_valid), .pgen_active(pgen_active));

//--- sim/vtpc_video_src.sv
// vtpc_video_src.sv: external pixel clock and raster timing source
// assumes: run is a level from the bench; clock stands still while run is low
`timescale 1ns/1ps
module vtpc_video_src #(
	parameter int      HT   = 10,
	parameter int      VT   = 4,
	parameter int      HA   = 6,
	parameter int      VA   = 2,
	parameter realtime HALF = 155.0
) (
	input wire logic run,
	output logic     pix_clk,
	output logic     de,
	output logic     hs,
	output logic     vs
);
	int h;
	int v;
	// raster moves on the falling edge so levels are stable at the rising one
	initial begin
		{pix_clk, de, hs, vs} = 4'h0;
		h = 0;
		v = 0;
		forever begin
			wait (run);
			#HALF pix_clk = 1'b1;
			#HALF pix_clk = 1'b0;
			h = (h + 1) % HT;
			if (h == 0)
				v = (v + 1) % VT;
			hs = (h < 1);
			vs = (v < 1);
			de = (h >= 2 && h < 2 + HA && v >= 1 && v < 1 + VA);
		end
	end
endmodule

//--- sim/tb.sv
// tb.sv: self-checking bench for the test pattern control block
// assumes: checker bound to vtpc_top, partner model drives the video pins
`timescale 1ns/1ps
`include "vtpc_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
	import vtpc_pkg::*;
	localparam logic [9:0] A_CTRL = {`VTPC_IDX_CTRL, 2'b00};
	localparam logic [9:0] A_CFG  = {`VTPC_IDX_CFG, 2'b00};
	localparam logic [9:0] A_IA   = {`VTPC_IDX_IADDR, 2'b00};
	localparam logic [9:0] A_ID   = {`VTPC_IDX_IDATA, 2'b00};
	localparam logic [9:0] A_ST   = {`VTPC_IDX_STAT, 2'b00};
	typedef struct { logic [7:0] cfg; logic run; int lo; int hi; } vtpc_row_t;
	// self rows: divider 1 gives a step every 2 cycles; pixel clock 310 ns
	vtpc_row_t   rows [7] = '{'{8'h04, 0, 619, 621}, '{8'h0c, 0, 0, 0},
		'{8'h0c, 1, 199, 201}, '{8'h00, 0, 0, 0}, '{8'h00, 1, 199, 201},
		'{8'h08, 1, 199, 201}, '{8'h08, 0, 0, 0}};
	logic [7:0]  tv [16] = '{8'h08, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00,
		8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h02, 8'h0c, 8'h01};
	logic        pclk, presetn, psel, penable, pwrite, run, pix_clk, ext_de, ext_hs, ext_vs;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, video_valid, pgen_active, eb;
	logic [7:0]  rb;
	vtpc_pixel_t video_out, p;
	int          error_cnt, compares, cyc, v, d, k, t1, t2, hc, vc;
	vtpc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pix_clk_in(pix_clk), .ext_de_in(ext_de), .ext_hs_in(ext_hs),
		.ext_vs_in(ext_vs), .video_out(video_out), .video_valid(video_valid),
		.pgen_active(pgen_active));
	vtpc_video_src src_u (.run(run), .pix_clk(pix_clk), .de(ext_de), .hs(ext_hs), .vs(ext_vs));
	////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] dd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, dd};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rb = prdata[7:0];
		eb = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [9:0] a, input logic [7:0] e, input logic er);
		apb(1'b0, a, 8'h00);
		`CHK({rb, eb}, {e, er})
	endtask
	task automatic count_win(input int n);
		v = 0;
		d = 0;
		hc = 0;
		vc = 0;
		repeat (n) begin
			@(posedge pclk);
			#1;
			v += (video_valid === 1'b1);
			d += (video_valid === 1'b1 && video_out.de === 1'b1);
			hc += (video_valid === 1'b1 && video_out.hs === 1'b1);
			vc += (video_valid === 1'b1 && video_out.vs === 1'b1);
		end
	endtask
	// first active pixel, k counts cycles waited
	task automatic grab();
		k = 0;
		do begin
			@(posedge pclk);
			#1;
			k++;
		end while (!(video_valid === 1'b1 && video_out.de === 1'b1) && k < 500);
		p = video_out;
	endtask
	task automatic wait_pat(input logic [2:0] pat, output int t);
		repeat (100) begin
			apb(1'b0, A_ST, 8'h00);
			if (rb[3:1] === pat)
				break;
		end
		t = cyc;
	endtask
	task automatic note(input string s);
		$display("done: %s", s);
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, run, cyc, error_cnt, compares} = '0;
		paddr = '0;
		pwdata = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, A_IA, 8'(i));
			apb(1'b1, A_ID, tv[i]);
		end
		apb(1'b1, A_CTRL, 8'h01);
		foreach (rows[i]) begin
			run <= rows[i].run;
			apb(1'b1, A_CFG, rows[i].cfg);
			repeat (50) @(posedge pclk);
			count_win(1240);
			`CHK(v >= rows[i].lo && v <= rows[i].hi, 1'b1)
			// external raster: 12 of 40 pixels active, one hsync pixel in 10
			if (!rows[i].cfg[`VTPC_CFG_TSEL] && rows[i].run) begin
				`CHK(d >= 59 && d <= 61, 1'b1)
				`CHK(hc >= 19 && hc <= 21, 1'b1)
			end
		end
		note("timing sources");
		run <= 1'b0;
		apb(1'b1, A_CFG, 8'h04);
		repeat (50) @(posedge pclk);
		count_win(256);
		`CHK(d, 32)
		`CHK(hc, 16)
		`CHK(vc, 32)
		grab();
		`CHK({p.r, p.g, p.b}, 24'hffffff)
		apb(1'b1, A_CTRL, 8'h11);
		apb(1'b1, A_CFG, 8'h06);
		grab();
		`CHK({p.r, p.g, p.b}, 24'hffffff)
		apb(1'b1, A_CFG, 8'h16);
		grab();
		`CHK({p.r, p.g, p.b}, 24'hfcfcfc)
		note("colors");
		apb(1'b1, A_CTRL, 8'h10);
		count_win(200);
		`CHK(v, 0)
		apb(1'b1, A_CTRL, 8'h11);
		grab();
		`CHK(k >= 36 && k <= 44, 1'b1)
		note("enable");
		apb(1'b1, A_CFG, 8'h05);
		apb(1'b1, A_CTRL, 8'h21);
		wait_pat(3'h3, t1);
		wait_pat(3'h2, t2);
		`CHK(t2 - t1 >= 125 && t2 - t1 <= 131, 1'b1)
		apb(1'b1, A_CFG, 8'h04);
		repeat (300) @(posedge pclk);
		rchk(A_ST, 8'h05, 1'b0);
		note("scroll");
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		`CHK(pgen_active, 1'b0)
		rchk(A_CFG, 8'h00, 1'b0);
		rchk(A_IA, 8'h00, 1'b0);
		rchk(A_ID, 8'h00, 1'b0);
		apb(1'b1, A_IA, 8'h0d);
		rchk(A_IA, 8'h0d, 1'b0);
		apb(1'b1, A_ID, 8'h5a);
		apb(1'b1, A_IA, 8'h0e);
		apb(1'b1, A_ID, 8'h33);
		apb(1'b1, A_IA, 8'h0d);
		rchk(A_ID, 8'h5a, 1'b0);
		apb(1'b1, A_IA, 8'h20);
		apb(1'b1, A_ID, 8'h77);
		rchk(A_ID, 8'h00, 1'b0);
		rchk(10'h1a4, 8'h00, 1'b1);
		apb(1'b1, A_ST, 8'hff);
		rchk(A_ST, 8'h00, 1'b0);
		apb(1'b1, A_CFG, 8'hff);
		rchk(A_CFG, 8'h7f, 1'b0);
		note("registers");
		print_verdict();
	end
endmodule
